// ==== hdl/hpi_seq.sv ====
// sixteen-bit host port access sequencer, multiplexed and simplex modes
// How it works
// RL1: address phase parameter clamped to at least two
// RL2: setup phase parameter clamped to at least two
// RL3: strobe phase parameter clamped to at least one
// RL4: address phase lasts one clock past wait
// RL5: setup phase lasts one clock past wait
// RL6: wait stalls address, setup and strobe phases anytime
// RL7: address driven in same clock as select
// RL8: strobe starts six or more cycles after select
// RL9: strobe stays asserted for its phase length
// RL10: write data valid before strobe rises
// RL11: write data held through hold phase
// RL12: read data sampled at strobe phase end
// RL13: partner provides read data before sampling
// RL14: recovery gap of two to sixteen cycles
// RL15: address held whole access, select to release
// RL16: every phase counted in bus clocks
// RL17: multiplexed shares lines, simplex separates them
// RL18: wait pin synchronised before stalling counters
`timescale 1ns/1ps
module hpi_seq (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic write_en,
  input wire logic mux_mode,
  input wire logic [15:0] address_in,
  input wire logic [15:0] wdata_in,
  input wire logic [3:0] address_phase_param,
  input wire logic [3:0] setup_phase_param,
  input wire logic [3:0] strobe_phase_param,
  input wire logic [5:0] hold_phase_param,
  input wire logic [3:0] recovery_phase_param,
  input wire logic host_wait_ready,
  output logic busy,
  output logic done,
  output logic [15:0] rdata_out,
  output logic chip_select_low,
  output logic host_data_strobe_one_low,
  output logic [15:0] addr_out,
  output logic [15:0] data_out,
  output logic data_oe,
  input wire logic [15:0] data_in
);
  // ----------------------------------------------------------------
  // state and latched request
  // ----------------------------------------------------------------
  hpi_seq_pkg::phase_t state_q, state_d; // current phase
  logic [5:0] cnt_q, cnt_d; // clocks left in phase, minus one
  logic [15:0] addr_q; // address of the access
  logic [15:0] wdata_q; // write data of the access
  logic wr_q; // access is a write
  logic mux_q; // access uses shared lines
  logic [15:0] rdata_q; // sampled read data
  logic done_q; // end-of-access pulse
  logic tail_q; // wait was seen last clock
  logic wait_s; // synchronised wait level

  // ----------------------------------------------------------------
  // wait pin crossing
  // ----------------------------------------------------------------
  // pin is asynchronous to clk, so it never stalls a counter raw
  wait_sync u_wait_sync ( // see RL18
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(host_wait_ready),
    .sync_out(wait_s)
  );

  // ----------------------------------------------------------------
  // clamped phase lengths
  // ----------------------------------------------------------------
  // software may write too small a value; clamping beats a bus fault
  logic [3:0] addr_eff, setup_eff, strobe_eff, recov_eff;
  logic [5:0] hold_eff;
  assign addr_eff = (address_phase_param < hpi_seq_pkg::ADDR_MIN) ?
                    hpi_seq_pkg::ADDR_MIN : address_phase_param; // see RL1
  assign setup_eff = (setup_phase_param < hpi_seq_pkg::SETUP_MIN) ?
                     hpi_seq_pkg::SETUP_MIN : setup_phase_param; // see RL2
  assign strobe_eff = (strobe_phase_param < hpi_seq_pkg::STROBE_MIN) ?
                      hpi_seq_pkg::STROBE_MIN : strobe_phase_param; // see RL3
  assign recov_eff = (recovery_phase_param < hpi_seq_pkg::RECOV_MIN) ?
                     hpi_seq_pkg::RECOV_MIN : recovery_phase_param; // see RL14
  // hold clamp keeps write data 4 to 36 clocks past the strobe
  assign hold_eff = (hold_phase_param < hpi_seq_pkg::HOLD_MIN) ? hpi_seq_pkg::HOLD_MIN :
                    (hold_phase_param > hpi_seq_pkg::HOLD_MAX) ? hpi_seq_pkg::HOLD_MAX :
                    hold_phase_param; // see RL11

  // ----------------------------------------------------------------
  // phase end decode
  // ----------------------------------------------------------------
  logic stall_ph; // phase that wait may stretch
  logic stall; // hold the counter this clock
  logic ph_end; // last clock of the phase
  assign stall_ph = (state_q == hpi_seq_pkg::ST_ADDR) ||
                    (state_q == hpi_seq_pkg::ST_SETUP) ||
                    (state_q == hpi_seq_pkg::ST_STROBE);
  // tail adds one clock after wait drops, so the phase outlives it
  assign stall = stall_ph && (wait_s || tail_q); // see RL4 see RL5 see RL6
  assign ph_end = (cnt_q == 6'h00) && !stall; // see RL16

  // ----------------------------------------------------------------
  // next phase and counter load
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (stall) begin
      cnt_d = cnt_q; // frozen while the partner waits
    end else if (cnt_q != 6'h00) begin
      cnt_d = cnt_q - 6'h01;
    end
    unique case (state_q)
      hpi_seq_pkg::ST_IDLE: begin
        if (start) begin
          state_d = hpi_seq_pkg::ST_ADDR;
          cnt_d = {2'h0, addr_eff};
        end
      end
      hpi_seq_pkg::ST_ADDR: begin
        if (ph_end) begin
          state_d = hpi_seq_pkg::ST_SETUP;
          cnt_d = {2'h0, setup_eff};
        end
      end
      hpi_seq_pkg::ST_SETUP: begin
        if (ph_end) begin
          state_d = hpi_seq_pkg::ST_STROBE; // see RL8
          cnt_d = {2'h0, strobe_eff};
        end
      end
      hpi_seq_pkg::ST_STROBE: begin
        if (ph_end) begin
          state_d = hpi_seq_pkg::ST_HOLD; // see RL9
          cnt_d = hold_eff;
        end
      end
      hpi_seq_pkg::ST_HOLD: begin
        if (ph_end) begin
          state_d = hpi_seq_pkg::ST_RECOV;
          cnt_d = {2'h0, recov_eff};
        end
      end
      hpi_seq_pkg::ST_RECOV: begin
        if (ph_end) begin
          state_d = hpi_seq_pkg::ST_IDLE; // see RL14
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequence registers
  // ----------------------------------------------------------------
  logic accept; // request taken this clock
  logic rd_sample; // read capture clock
  assign accept = (state_q == hpi_seq_pkg::ST_IDLE) && start;
  // partner has had the whole strobe phase to drive the data
  assign rd_sample = (state_q == hpi_seq_pkg::ST_STROBE) && ph_end && !wr_q; // see RL12 see RL13

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= hpi_seq_pkg::ST_IDLE;
      cnt_q <= 6'h00;
      tail_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      tail_q <= wait_s;
    end
  end

  // request latch: address and data stay put for the whole access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      wr_q <= 1'b0;
      mux_q <= 1'b0;
    end else if (accept) begin
      addr_q <= address_in; // see RL15
      wdata_q <= wdata_in;
      wr_q <= write_en;
      mux_q <= mux_mode;
    end
  end

  // read capture and completion pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == hpi_seq_pkg::ST_HOLD) && ph_end;
      if (rd_sample) begin
        rdata_q <= data_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin decode
  // ----------------------------------------------------------------
  logic in_access; // select window: address through hold
  logic drv_addr; // shared lines carry the address
  logic drv_wdata; // data lines carry write data
  assign in_access = (state_q != hpi_seq_pkg::ST_IDLE) &&
                     (state_q != hpi_seq_pkg::ST_RECOV);
  assign drv_addr = mux_q && (state_q == hpi_seq_pkg::ST_ADDR);
  // write data up from setup (simplex: from address) through hold, both sides of the strobe
  assign drv_wdata = wr_q && in_access && (state_q != hpi_seq_pkg::ST_ADDR ||
                     !mux_q); // see RL10 see RL11
  assign chip_select_low = !in_access;
  assign host_data_strobe_one_low = (state_q != hpi_seq_pkg::ST_STROBE); // see RL9
  // simplex keeps address on its own lines; multiplexed shares them
  assign addr_out = addr_q; // see RL7 see RL17
  assign data_out = drv_addr ? addr_q : wdata_q; // see RL17
  assign data_oe = drv_addr || drv_wdata;
  assign busy = (state_q != hpi_seq_pkg::ST_IDLE);
  assign done = done_q;
  assign rdata_out = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [5:0] dwell_q; // clocks spent in the present phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dwell_q <= 6'h00;
    end else if (state_d != state_q) begin
      dwell_q <= 6'h00;
    end else if (dwell_q != 6'h3F) begin
      dwell_q <= dwell_q + 6'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_addr_len: assert property ( // see RL1
    state_q == hpi_seq_pkg::ST_ADDR && state_d != state_q |-> dwell_q >= 6'h02)
    else $error("address phase shorter than three clocks");
  chk_setup_len: assert property ( // see RL2
    state_q == hpi_seq_pkg::ST_SETUP && state_d != state_q |-> dwell_q >= 6'h02)
    else $error("setup phase shorter than three clocks");
  chk_strobe_len: assert property ( // see RL3
    $fell(host_data_strobe_one_low) |=> !host_data_strobe_one_low)
    else $error("strobe lasted under two clocks");
  chk_addr_tail: assert property ( // see RL4
    state_q == hpi_seq_pkg::ST_ADDR && $fell(wait_s) |-> state_d == hpi_seq_pkg::ST_ADDR)
    else $error("address phase ended as wait dropped");
  chk_setup_tail: assert property ( // see RL5
    state_q == hpi_seq_pkg::ST_SETUP && $fell(wait_s) |-> state_d == hpi_seq_pkg::ST_SETUP)
    else $error("setup phase ended as wait dropped");
  chk_wait_stall: assert property ( // see RL6
    state_q == hpi_seq_pkg::ST_STROBE && wait_s |=> state_q == hpi_seq_pkg::ST_STROBE)
    else $error("strobe phase left while wait active");
  chk_select_addr: assert property ( // see RL7
    $fell(chip_select_low) |-> addr_out == $past(address_in) && (!mux_q || data_oe))
    else $error("address not driven with select");
  chk_select_gap: assert property ( // see RL8
    $fell(chip_select_low) |-> host_data_strobe_one_low [*6])
    else $error("strobe too soon after select");
  chk_wdata_hold: assert property ( // see RL11
    $rose(host_data_strobe_one_low) && wr_q |-> data_oe [*4])
    else $error("write data dropped within four clocks of strobe");
  chk_recov_gap: assert property ( // see RL14
    $rose(chip_select_low) |-> chip_select_low [*2])
    else $error("recovery gap under two clocks");
  chk_read_take: assert property ( // see RL12
    rd_sample |=> rdata_out == $past(data_in))
    else $error("read data not captured at strobe end");

  cov_write: cover property ($rose(done) && wr_q);
  cov_read: cover property ($rose(done) && !wr_q);
  cov_wait_strobe: cover property (state_q == hpi_seq_pkg::ST_STROBE && wait_s);
  cov_mux_simplex: cover property (accept ##1 !mux_q);
endmodule // hpi_seq

// ==== hdl/hpi_seq_pkg.sv ====
// package: phase limits, widths and states of the host-port sequencer
package hpi_seq_pkg;
  // ----------------------------------------------------------------
  // bus widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16; // address lines
  localparam int DATA_W = 16; // sixteen-bit host port data
  localparam int PARAM_W = 4; // address, setup, strobe, recovery fields
  localparam int HOLD_W = 6; // hold phase field
  localparam int CNT_W = 6; // phase down-counter

  // ----------------------------------------------------------------
  // least and greatest legal phase parameter values (phase lasts value + 1 clocks)
  // ----------------------------------------------------------------
  localparam logic [PARAM_W-1:0] ADDR_MIN = 4'h2; // three clocks
  localparam logic [PARAM_W-1:0] SETUP_MIN = 4'h2; // three clocks
  localparam logic [PARAM_W-1:0] STROBE_MIN = 4'h1; // two clocks
  localparam logic [PARAM_W-1:0] RECOV_MIN = 4'h1; // gap of two clocks
  localparam logic [HOLD_W-1:0] HOLD_MIN = 6'h03; // data held four clocks
  localparam logic [HOLD_W-1:0] HOLD_MAX = 6'h23; // data held 36 clocks

  // ----------------------------------------------------------------
  // access sequence
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_RECOV
  } phase_t;
endpackage

// ==== hdl/wait_sync.sv ====
// two-flop synchroniser for the asynchronous wait pin
`timescale 1ns/1ps
module wait_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic async_in,
  output logic sync_out
);
  // ----------------------------------------------------------------
  // first stage feeds only the second stage
  // ----------------------------------------------------------------
  logic meta_q; // may go metastable, nothing else reads it
  logic sync_q; // safe copy

  // two stages on every rising edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // wait_sync

// ==== verification/dsp_host_model.sv ====
// partner model: host port of the signal processor, read data and wait pin
`timescale 1ns/1ps
module dsp_host_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chip_select_low,
  input wire logic host_data_strobe_one_low,
  input wire logic [15:0] word,
  input wire logic [2:0] wait_len,
  input wire logic wait_in_strobe,
  output logic host_wait_ready,
  output logic [15:0] data_in
);
  // ----------------------------------------------------------------
  // clocks since select fell
  // ----------------------------------------------------------------
  logic [3:0] since_cs_q; // saturates so a long access never wraps
  always_ff @(posedge clk) begin
    if (sys_rst || chip_select_low) begin
      since_cs_q <= 4'h0;
    end else if (since_cs_q != 4'hF) begin
      since_cs_q <= since_cs_q + 4'h1;
    end
  end
  // clocks since strobe fell, so a wait can land inside the strobe phase
  logic [3:0] since_ds_q; // saturates like the select counter
  always_ff @(posedge clk) begin
    if (sys_rst || host_data_strobe_one_low) begin
      since_ds_q <= 4'h0;
    end else if (since_ds_q != 4'hF) begin
      since_ds_q <= since_ds_q + 4'h1;
    end
  end
  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // wait from the second select clock, or the second strobe clock, for wait_len clocks
  assign host_wait_ready = wait_in_strobe ?
    (!host_data_strobe_one_low && (since_ds_q >= 4'h1) &&
     (since_ds_q <= {1'b0, wait_len})) :
    (!chip_select_low && (since_cs_q >= 4'h1) && (since_cs_q <= {1'b0, wait_len}));
  // word valid while strobed; inverse otherwise so stale data never matches
  assign data_in = host_data_strobe_one_low ? ~word : word;
endmodule // dsp_host_model

// ==== verification/tb_dsp_host_port_sequencer.sv ====
// testbench: random and corner accesses through the host port sequencer
`timescale 1ns/1ps
module tb_dsp_host_port_sequencer;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 1'b0, sys_rst = 1'b1, start = 1'b0, write_en = 1'b0, mux_mode = 1'b0;
  logic [15:0] address_in = 16'h0000, wdata_in = 16'h0000, word = 16'h0000;
  logic [3:0] ap = 4'h2, sp = 4'h2, tp = 4'h1, rp = 4'h1; // phase params
  logic [5:0] hp = 6'h03; // hold param
  logic [2:0] wait_len = 3'h0; // wait length the partner applies
  logic wait_in_strobe = 1'b0; // partner waits under the strobe, not after select
  logic host_wait_ready, busy, done, chip_select_low, host_data_strobe_one_low, data_oe;
  logic [15:0] rdata_out, addr_out, data_out, data_in;
  int n_fail = 0, checks_done = 0, cycles = 0;
  always #50 clk = ~clk; // 10 MHz
  hpi_seq hpi_seq_i (.clk(clk), .sys_rst(sys_rst), .start(start), .write_en(write_en),
    .mux_mode(mux_mode), .address_in(address_in), .wdata_in(wdata_in),
    .address_phase_param(ap), .setup_phase_param(sp), .strobe_phase_param(tp),
    .hold_phase_param(hp), .recovery_phase_param(rp), .host_wait_ready(host_wait_ready),
    .busy(busy), .done(done), .rdata_out(rdata_out), .chip_select_low(chip_select_low),
    .host_data_strobe_one_low(host_data_strobe_one_low), .addr_out(addr_out),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  dsp_host_model dsp_host_model_i (.clk(clk), .sys_rst(sys_rst),
    .chip_select_low(chip_select_low), .host_data_strobe_one_low(host_data_strobe_one_low),
    .word(word), .wait_len(wait_len), .wait_in_strobe(wait_in_strobe),
    .host_wait_ready(host_wait_ready), .data_in(data_in));
  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard, well above the longest expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  // expected phase length: clamped parameter plus one clock
  function automatic int plen(input int v, input int lo, input int hi);
    return ((v < lo) ? lo : ((v > hi) ? hi : v)) + 1;
  endfunction
  // ----------------------------------------------------------------
  // one access, watched cycle by cycle
  // ----------------------------------------------------------------
  task automatic access(input logic wr, input logic mx, input logic [3:0] a, input logic [3:0] s,
    input logic [3:0] t, input logic [5:0] h, input logic [3:0] r, input logic [2:0] wt,
    input logic ws);
    int n, c_cs, c_st, c_hd, c_rc, n_done, x_cs, x_st;
    logic seen_st;
    n = 0; c_cs = 0; c_st = 0; c_hd = 0; c_rc = 0; n_done = 0; seen_st = 1'b0;
    write_en = wr; mux_mode = mx; ap = a; sp = s; tp = t; hp = h; rp = r; wait_len = wt;
    wait_in_strobe = ws;
    address_in = 16'($urandom); wdata_in = 16'($urandom); word = 16'($urandom);
    start = 1'b1;
    @(posedge clk); #1;
    start = 1'b0;
    while (busy === 1'b1 && n < 200) begin
      if (chip_select_low === 1'b0) begin
        check(addr_out, address_in);
        if (host_data_strobe_one_low === 1'b0) begin
          c_st++; seen_st = 1'b1;
        end else if (seen_st) begin
          c_hd++;
        end else begin
          if (mx && (wt == 0 || ws) && c_cs < plen(a, 2, 15))
            check(data_out, address_in);
          // write data up ahead of the strobe: whole access simplex, after address mux
          if (wr && (!mx || ((wt == 0 || ws) && c_cs >= plen(a, 2, 15))))
            check({data_oe, data_out}, {1'b1, wdata_in});
          c_cs++;
        end
        // write data stands through strobe and hold
        if (wr && seen_st) check({data_oe, data_out}, {1'b1, wdata_in});
      end else begin
        c_rc++;
      end
      if (!wr && (!mx || seen_st)) check(data_oe, 1'b0);
      if (done === 1'b1) n_done++;
      @(posedge clk); #1;
      n++;
    end
    // a wait reaches the counters two clocks late and lasts one clock past its fall
    x_cs = plen(a, 2, 15) + plen(s, 2, 15) + ((wt > 0 && !ws) ? wt + 1 : 0);
    x_st = plen(t, 1, 15);
    // a strobe of three clocks or less is over before a strobe-time wait arrives
    if (ws && wt > 0 && x_st >= 4) x_st = x_st + wt + 1;
    check(c_cs, x_cs);
    check(c_st, x_st);
    check(c_hd, plen(h, 3, 35));
    check(c_rc, plen(r, 1, 15));
    check(n_done, 1);
    if (!wr) check(rdata_out, word);
    $display("access done wr=%0b mux=%0b wait=%0d", wr, mx, wt);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h3090f049));
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    access(1'b1, 1'b1, 4'h2, 4'h2, 4'h1, 6'h03, 4'h1, 3'h0, 1'b0); // smallest legal, mux write
    access(1'b0, 1'b0, 4'h0, 4'h0, 4'h0, 6'h00, 4'h0, 3'h0, 1'b0); // below minimum: clamped
    access(1'b1, 1'b0, 4'hF, 4'hF, 4'hF, 6'h3F, 4'hF, 3'h0, 1'b0); // longest, hold clamped
    access(1'b0, 1'b1, 4'h2, 4'h2, 4'h1, 6'h03, 4'h1, 3'h3, 1'b0); // wait stretches early phases
    access(1'b0, 1'b0, 4'h2, 4'h2, 4'h5, 6'h03, 4'h1, 3'h3, 1'b1); // wait stretches the strobe
    access(1'b1, 1'b1, 4'h2, 4'h2, 4'h3, 6'h03, 4'h1, 3'h4, 1'b1); // wait on a four-clock strobe
    for (int i = 0; i < 24; i++) begin
      access(1'($urandom), 1'($urandom), 4'($urandom), 4'($urandom), 4'($urandom),
        6'($urandom), 4'($urandom), 3'($urandom_range(0, 4)), 1'($urandom));
    end
    print_verdict();
  end
endmodule // tb_dsp_host_port_sequencer
